// ---- core/pdm_channel.sv ----
// Peripheral DMA channel: register file, request enables and transfer engine.
`timescale 1ns/1ps
`default_nettype none

module pdm_channel (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // Register port
   input wire logic [pdm_pkg::ADDR_W-1:0] reg_addr_i,
   input wire logic [pdm_pkg::DATA_W-1:0] reg_wdata_i,
   input wire logic reg_we_i,
   input wire logic reg_re_i,
   output logic [pdm_pkg::DATA_W-1:0] reg_rdata_o,
   // Peripheral receive side
   input wire logic rx_ready_i,
   input wire logic [pdm_pkg::DATA_W-1:0] rx_data_i,
   output logic rx_taken_o,
   output logic rx_end_o,
   // Peripheral transmit side
   input wire logic tx_ready_i,
   output logic [pdm_pkg::DATA_W-1:0] tx_data_o,
   output logic tx_load_o,
   output logic tx_end_o,
   // System bus memory master
   output pdm_pkg::pdm_mem_req_t mem_o,
   input wire logic mem_ack_i,
   input wire logic [pdm_pkg::DATA_W-1:0] mem_rdata_i
);

   // ==========================================================
   // Declarations
   pdm_pkg::pdm_dir_wr_t rx_wr;
   pdm_pkg::pdm_dir_wr_t tx_wr;
   pdm_pkg::pdm_dir_regs_t rx_regs;
   pdm_pkg::pdm_dir_regs_t tx_regs;
   logic rx_step;
   logic tx_step;

   logic rx_req_enable;
   logic tx_req_enable;
   logic next_rx_req_enable;
   logic next_tx_req_enable;
   logic [pdm_pkg::DATA_W-1:0] next_reg_rdata;
   logic cmd_write;

   pdm_pkg::pdm_state_t state;
   pdm_pkg::pdm_state_t next_state;
   pdm_pkg::pdm_mem_req_t next_mem;
   logic next_rx_taken;
   logic next_tx_load;
   logic [pdm_pkg::DATA_W-1:0] next_tx_data;
   logic next_rx_step;
   logic next_tx_step;
   logic rx_can_go;
   logic tx_can_go;
   logic step_pending;

   // ==========================================================
   // Helpers
   // Both directions share one start test, so their conditions cannot drift apart.
   // A direction starts only when it is asked, enabled, has words left and no step
   // is still on its way into the pointer and counter registers.
   function automatic logic dir_can_go(input logic ready, input logic enable, input logic busy,
      input logic [pdm_pkg::CNT_W-1:0] cnt);
      dir_can_go = ready && enable && !busy && (cnt != pdm_pkg::CNT_RESET);
   endfunction

   // ==========================================================
   // Write decode
   always_comb begin
      rx_wr = '0;
      tx_wr = '0;
      cmd_write = 1'b0;
      if (reg_we_i) begin
         case (reg_addr_i)
            pdm_pkg::OFF_RX_CUR_PTR: begin
               rx_wr.cur_ptr = 1'b1;
            end
            pdm_pkg::OFF_RX_CUR_CNT: begin
               rx_wr.cur_cnt = 1'b1;
            end
            pdm_pkg::OFF_TX_CUR_PTR: begin
               tx_wr.cur_ptr = 1'b1;
            end
            pdm_pkg::OFF_TX_CUR_CNT: begin
               tx_wr.cur_cnt = 1'b1;
            end
            pdm_pkg::OFF_RX_NXT_PTR: begin
               rx_wr.nxt_ptr = 1'b1;
            end
            pdm_pkg::OFF_RX_NXT_CNT: begin
               rx_wr.nxt_cnt = 1'b1;
            end
            pdm_pkg::OFF_TX_NXT_PTR: begin
               tx_wr.nxt_ptr = 1'b1;
            end
            pdm_pkg::OFF_TX_NXT_CNT: begin
               tx_wr.nxt_cnt = 1'b1;
            end
            pdm_pkg::OFF_COMMAND: begin
               cmd_write = 1'b1;
            end
            default: begin
               cmd_write = 1'b0;
            end
         endcase
      end
   end

   // ==========================================================
   // Direction register sets
   pdm_dir u_rx_dir (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .wr_i(rx_wr),
      .wdata_i(reg_wdata_i),
      .step_i(rx_step),
      .regs_o(rx_regs),
      .end_o(rx_end_o)
   );

   pdm_dir u_tx_dir (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .wr_i(tx_wr),
      .wdata_i(reg_wdata_i),
      .step_i(tx_step),
      .regs_o(tx_regs),
      .end_o(tx_end_o)
   );

   // ==========================================================
   // Request enables and read data
   always_comb begin
      next_rx_req_enable = rx_req_enable;
      next_tx_req_enable = tx_req_enable;
      if (cmd_write) begin
         if (reg_wdata_i[pdm_pkg::BIT_RX_REQ_DISABLE]) begin
            next_rx_req_enable = 1'b0;
         end else if (reg_wdata_i[pdm_pkg::BIT_RX_REQ_ENABLE]) begin
            next_rx_req_enable = 1'b1;
         end
         if (reg_wdata_i[pdm_pkg::BIT_TX_REQ_DISABLE]) begin
            next_tx_req_enable = 1'b0;
         end else if (reg_wdata_i[pdm_pkg::BIT_TX_REQ_ENABLE]) begin
            next_tx_req_enable = 1'b1;
         end
      end

      // Read data lives for one cycle only; idle cycles return zero.
      next_reg_rdata = pdm_pkg::WORD_ZERO;
      if (reg_re_i) begin
         case (reg_addr_i)
            pdm_pkg::OFF_RX_CUR_PTR: begin
               next_reg_rdata = rx_regs.cur_ptr;
            end
            pdm_pkg::OFF_RX_CUR_CNT: begin
               next_reg_rdata = pdm_pkg::pdm_cnt_word(rx_regs.cur_cnt);
            end
            pdm_pkg::OFF_TX_CUR_PTR: begin
               next_reg_rdata = tx_regs.cur_ptr;
            end
            pdm_pkg::OFF_TX_CUR_CNT: begin
               next_reg_rdata = pdm_pkg::pdm_cnt_word(tx_regs.cur_cnt);
            end
            pdm_pkg::OFF_RX_NXT_PTR: begin
               next_reg_rdata = rx_regs.nxt_ptr;
            end
            pdm_pkg::OFF_RX_NXT_CNT: begin
               next_reg_rdata = pdm_pkg::pdm_cnt_word(rx_regs.nxt_cnt);
            end
            pdm_pkg::OFF_TX_NXT_PTR: begin
               next_reg_rdata = tx_regs.nxt_ptr;
            end
            pdm_pkg::OFF_TX_NXT_CNT: begin
               next_reg_rdata = pdm_pkg::pdm_cnt_word(tx_regs.nxt_cnt);
            end
            pdm_pkg::OFF_STATUS: begin
               next_reg_rdata[pdm_pkg::BIT_RX_STATUS] = rx_req_enable;
               next_reg_rdata[pdm_pkg::BIT_TX_STATUS] = tx_req_enable;
            end
            default: begin
               // The command register is write-only and unmapped words read zero.
               next_reg_rdata = pdm_pkg::WORD_ZERO;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         rx_req_enable <= 1'b0;
         tx_req_enable <= 1'b0;
         reg_rdata_o <= pdm_pkg::WORD_ZERO;
      end else begin
         rx_req_enable <= next_rx_req_enable;
         tx_req_enable <= next_tx_req_enable;
         reg_rdata_o <= next_reg_rdata;
      end
   end

   // ==========================================================
   // Transfer engine
   // Only one bus access is in flight at a time, which keeps the memory side
   // simple at the cost of two idle cycles between transfers.
   always_comb begin
      // The pointer and counter move one cycle after the step pulse, so a start in
      // that cycle would reuse the old address and could run one word past the buffer.
      step_pending = rx_step | tx_step;
      rx_can_go = dir_can_go(rx_ready_i, rx_req_enable, step_pending, rx_regs.cur_cnt);
      tx_can_go = dir_can_go(tx_ready_i, tx_req_enable, step_pending, tx_regs.cur_cnt);
      next_state = state;
      next_mem = mem_o;
      next_rx_taken = 1'b0;
      next_tx_load = 1'b0;
      next_tx_data = tx_data_o;
      next_rx_step = 1'b0;
      next_tx_step = 1'b0;
      case (state)
         pdm_pkg::ST_IDLE: begin
            // Receive requests are served ahead of transmit requests.
            if (rx_can_go) begin
               next_mem.req = 1'b1;
               next_mem.we = 1'b1;
               next_mem.addr = rx_regs.cur_ptr;
               next_mem.wdata = rx_data_i;
               next_rx_taken = 1'b1;
               next_state = pdm_pkg::ST_RX_MEM;
            end else if (tx_can_go) begin
               next_mem.req = 1'b1;
               next_mem.we = 1'b0;
               next_mem.addr = tx_regs.cur_ptr;
               next_state = pdm_pkg::ST_TX_MEM;
            end
         end
         pdm_pkg::ST_RX_MEM: begin
            if (mem_ack_i) begin
               next_mem.req = 1'b0;
               next_mem.we = 1'b0;
               next_rx_step = 1'b1;
               next_state = pdm_pkg::ST_IDLE;
            end
         end
         pdm_pkg::ST_TX_MEM: begin
            if (mem_ack_i) begin
               next_mem.req = 1'b0;
               next_tx_data = mem_rdata_i;
               next_tx_load = 1'b1;
               next_tx_step = 1'b1;
               next_state = pdm_pkg::ST_IDLE;
            end
         end
         default: begin
            next_mem.req = 1'b0;
            next_mem.we = 1'b0;
            next_state = pdm_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         state <= pdm_pkg::ST_IDLE;
         mem_o <= '{1'b0, 1'b0, pdm_pkg::PTR_RESET, pdm_pkg::WORD_ZERO};
         rx_taken_o <= 1'b0;
         tx_load_o <= 1'b0;
         tx_data_o <= pdm_pkg::WORD_ZERO;
         rx_step <= 1'b0;
         tx_step <= 1'b0;
      end else begin
         state <= next_state;
         mem_o <= next_mem;
         rx_taken_o <= next_rx_taken;
         tx_load_o <= next_tx_load;
         tx_data_o <= next_tx_data;
         rx_step <= next_rx_step;
         tx_step <= next_tx_step;
      end
   end

endmodule

`default_nettype wire

// ---- core/pdm_dir.sv ----
// Pointer and counter registers of one transfer direction.
`timescale 1ns/1ps
`default_nettype none

module pdm_dir (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // Register writes
   input wire pdm_pkg::pdm_dir_wr_t wr_i,
   input wire logic [pdm_pkg::DATA_W-1:0] wdata_i,
   // One completed transfer
   input wire logic step_i,
   // State
   output pdm_pkg::pdm_dir_regs_t regs_o,
   output logic end_o
);

   pdm_pkg::pdm_dir_regs_t next_regs;
   logic next_end;
   logic end_set;
   logic end_clr;

   // ==========================================================
   // Next state
   always_comb begin
      next_regs = regs_o;
      end_set = 1'b0;
      end_clr = wr_i.cur_cnt | wr_i.nxt_cnt;
      if (step_i) begin
         next_regs.cur_ptr = regs_o.cur_ptr + pdm_pkg::PTR_STEP;
         next_regs.cur_cnt = regs_o.cur_cnt - pdm_pkg::CNT_STEP;
         // The flag only rises when no next buffer is waiting to be chained.
         end_set = (regs_o.cur_cnt == pdm_pkg::CNT_STEP) && (regs_o.nxt_cnt == pdm_pkg::CNT_RESET);
      end else if ((regs_o.cur_cnt == pdm_pkg::CNT_RESET) && (regs_o.nxt_cnt != pdm_pkg::CNT_RESET)) begin
         next_regs.cur_ptr = regs_o.nxt_ptr;
         next_regs.cur_cnt = regs_o.nxt_cnt;
         next_regs.nxt_cnt = pdm_pkg::CNT_RESET;
      end
      // A software write overrides the hardware update in the same cycle.
      if (wr_i.cur_ptr) begin
         next_regs.cur_ptr = wdata_i;
      end
      if (wr_i.cur_cnt) begin
         next_regs.cur_cnt = wdata_i[pdm_pkg::CNT_W-1:0];
      end
      if (wr_i.nxt_ptr) begin
         next_regs.nxt_ptr = wdata_i;
      end
      if (wr_i.nxt_cnt) begin
         next_regs.nxt_cnt = wdata_i[pdm_pkg::CNT_W-1:0];
      end
      // A new end event is never lost to a clear in the same cycle.
      next_end = end_set | (end_o & ~end_clr);
   end

   // ==========================================================
   // Registers
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         regs_o <= '{pdm_pkg::PTR_RESET, pdm_pkg::CNT_RESET, pdm_pkg::PTR_RESET, pdm_pkg::CNT_RESET};
         end_o <= 1'b0;
      end else begin
         regs_o <= next_regs;
         end_o <= next_end;
      end
   end

endmodule

`default_nettype wire

// ---- shared/pdm_pkg.sv ----
// Shared constants, types and helpers of the peripheral DMA channel.
`default_nettype none

package pdm_pkg;

   // ==========================================================
   // Widths
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int PTR_W = 32;
   localparam int CNT_W = 16;

   // ==========================================================
   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFF_RX_CUR_PTR = 12'h100;
   localparam logic [ADDR_W-1:0] OFF_RX_CUR_CNT = 12'h104;
   localparam logic [ADDR_W-1:0] OFF_TX_CUR_PTR = 12'h108;
   localparam logic [ADDR_W-1:0] OFF_TX_CUR_CNT = 12'h10c;
   localparam logic [ADDR_W-1:0] OFF_RX_NXT_PTR = 12'h110;
   localparam logic [ADDR_W-1:0] OFF_RX_NXT_CNT = 12'h114;
   localparam logic [ADDR_W-1:0] OFF_TX_NXT_PTR = 12'h118;
   localparam logic [ADDR_W-1:0] OFF_TX_NXT_CNT = 12'h11c;
   localparam logic [ADDR_W-1:0] OFF_COMMAND = 12'h120;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h124;

   // ==========================================================
   // Field positions of the command and status registers
   localparam int BIT_RX_REQ_ENABLE = 0;
   localparam int BIT_RX_REQ_DISABLE = 1;
   localparam int BIT_TX_REQ_ENABLE = 8;
   localparam int BIT_TX_REQ_DISABLE = 9;
   localparam int BIT_RX_STATUS = 0;
   localparam int BIT_TX_STATUS = 8;

   // ==========================================================
   // Reset values and step sizes
   localparam logic [PTR_W-1:0] PTR_RESET = 32'h0000_0000;
   localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
   localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;
   localparam logic [PTR_W-1:0] PTR_STEP = 32'h0000_0001;
   localparam logic [CNT_W-1:0] CNT_STEP = 16'h0001;

   // ==========================================================
   // Types
   typedef struct packed {
      logic [PTR_W-1:0] cur_ptr;
      logic [CNT_W-1:0] cur_cnt;
      logic [PTR_W-1:0] nxt_ptr;
      logic [CNT_W-1:0] nxt_cnt;
   } pdm_dir_regs_t;

   typedef struct packed {
      logic cur_ptr;
      logic cur_cnt;
      logic nxt_ptr;
      logic nxt_cnt;
   } pdm_dir_wr_t;

   typedef struct packed {
      logic req;
      logic we;
      logic [PTR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } pdm_mem_req_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_RX_MEM = 3'h2,
      ST_TX_MEM = 3'h4
   } pdm_state_t;

   // ==========================================================
   // Helpers
   // Counters read back zero-extended; the unused upper bits read as zero.
   function automatic logic [DATA_W-1:0] pdm_cnt_word(input logic [CNT_W-1:0] cnt);
      pdm_cnt_word = {{(DATA_W-CNT_W){1'b0}}, cnt};
   endfunction

endpackage

`default_nettype wire

// ---- sim/pdm_channel_assertions.sv ----
// Concurrent checks on the ports of the peripheral DMA channel.
`timescale 1ns/1ps
`default_nettype none

module pdm_channel_assertions (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // Register port
   input wire logic [pdm_pkg::ADDR_W-1:0] reg_addr_i,
   input wire logic [pdm_pkg::DATA_W-1:0] reg_wdata_i,
   input wire logic reg_we_i,
   input wire logic reg_re_i,
   input wire logic [pdm_pkg::DATA_W-1:0] reg_rdata_o,
   // Peripheral and memory
   input wire logic [pdm_pkg::DATA_W-1:0] rx_data_i,
   input wire logic rx_taken_o,
   input wire logic [pdm_pkg::DATA_W-1:0] tx_data_o,
   input wire logic tx_load_o,
   input wire pdm_pkg::pdm_mem_req_t mem_o,
   input wire logic mem_ack_i,
   input wire logic [pdm_pkg::DATA_W-1:0] mem_rdata_i
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   // ==========================================================
   // Sequences
   sequence s_cmd_write;
      reg_we_i && reg_addr_i == pdm_pkg::OFF_COMMAND;
   endsequence
   sequence s_read_ack;
      mem_o.req && !mem_o.we && mem_ack_i;
   endsequence

   // ==========================================================
   // Register reads
   a_cmd_reads_zero: assert property (reg_re_i && reg_addr_i == pdm_pkg::OFF_COMMAND |=> reg_rdata_o == 32'h0)
      else $error("command register read back nonzero");
   a_status_spare_zero: assert property (reg_re_i && reg_addr_i == pdm_pkg::OFF_STATUS |=> (reg_rdata_o & 32'hfffffefe) == 32'h0)
      else $error("status spare bits nonzero");
   a_rx_cnt_upper: assert property (reg_re_i && reg_addr_i == pdm_pkg::OFF_RX_NXT_CNT |=> reg_rdata_o[31:16] == 16'h0)
      else $error("receive next count upper bits nonzero");
   a_tx_cnt_upper: assert property (reg_re_i && reg_addr_i == pdm_pkg::OFF_TX_NXT_CNT |=> reg_rdata_o[31:16] == 16'h0)
      else $error("transmit next count upper bits nonzero");

   // ==========================================================
   // Request enables
   // The edge of the write may still launch one transfer, so the window opens one cycle later.
   a_rx_refused: assert property (s_cmd_write ##0 reg_wdata_i[1] |=> ##1 !rx_taken_o [*8])
      else $error("receive word taken while disabled");
   a_tx_refused: assert property (s_cmd_write ##0 reg_wdata_i[9] |=> ##1 !($rose(mem_o.req) && !mem_o.we) [*8])
      else $error("transmit fetch started while disabled");

   // ==========================================================
   // Transfers
   a_rx_take_write: assert property (rx_taken_o |-> mem_o.req && mem_o.we && mem_o.wdata == rx_data_i)
      else $error("received word not written to memory");
   a_tx_load_data: assert property (s_read_ack |=> tx_load_o && tx_data_o == $past(mem_rdata_i))
      else $error("fetched word not loaded to transmitter");
   a_req_held: assert property (mem_o.req && !mem_ack_i |=> mem_o.req && $stable(mem_o))
      else $error("memory request changed before acknowledge");
   a_step_settles: assert property ($fell(mem_o.req) |=> !mem_o.req)
      else $error("transfer started before the previous step landed");
endmodule

bind pdm_channel pdm_channel_assertions chk_u (.clk_sys_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i,
   .reg_rdata_o, .rx_data_i, .rx_taken_o, .tx_data_o, .tx_load_o, .mem_o, .mem_ack_i, .mem_rdata_i);

`default_nettype wire

// ---- sim/pdm_partner.sv ----
// Behavioural serial peripheral and memory on the far side of the channel.
`timescale 1ns/1ps
`default_nettype none

module pdm_partner (
   // Clock, reset and bench controls
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic slow_i,
   input wire logic rx_send_i,
   input wire logic [31:0] rx_word_i,
   input wire logic tx_want_i,
   // Peripheral lines
   output logic rx_ready_o,
   output logic [31:0] rx_data_o,
   input wire logic rx_taken_i,
   output logic tx_ready_o,
   input wire logic tx_load_i,
   // Memory lines
   input wire pdm_pkg::pdm_mem_req_t mem_i,
   output logic mem_ack_o,
   output logic [31:0] mem_rdata_o
);
   logic [1:0] wait_cnt;

   // ==========================================================
   // Peripheral
   // Once a word is taken the data line carries its inverse, so a stale word cannot pass as fresh.
   always_ff @(posedge clk_sys_i) begin
      tx_ready_o <= !rst_i && tx_want_i && !tx_load_i;
      if (rst_i) begin
         rx_ready_o <= 1'b0;
         rx_data_o <= 32'h0000_0000;
      end else if (rx_send_i) begin
         rx_ready_o <= 1'b1;
         rx_data_o <= rx_word_i;
      end else if (rx_taken_i) begin
         rx_ready_o <= 1'b0;
         rx_data_o <= ~rx_data_o;
      end
   end

   // ==========================================================
   // Memory
   // Read data is only meaningful with the acknowledge; otherwise it toggles every cycle.
   always_ff @(posedge clk_sys_i) begin
      mem_ack_o <= 1'b0;
      mem_rdata_o <= ~mem_rdata_o;
      if (rst_i) begin
         wait_cnt <= 2'h0;
         mem_rdata_o <= 32'h0000_0000;
      end else if (mem_i.req && !mem_ack_o) begin
         if (wait_cnt >= (slow_i ? 2'h3 : 2'h0)) begin
            mem_ack_o <= 1'b1;
            wait_cnt <= 2'h0;
            mem_rdata_o <= mem_i.addr ^ 32'h5a5a_5a5a;
         end else begin
            wait_cnt <= wait_cnt + 2'h1;
         end
      end
   end
endmodule

`default_nettype wire

// ---- sim/tb_peripheral_dma_channel_ctrl.sv ----
// Self-checking testbench of the peripheral DMA channel.
`timescale 1ns/1ps
`default_nettype none

module tb_peripheral_dma_channel_ctrl;
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   logic [11:0] reg_addr_i = 12'h000;
   logic [31:0] reg_wdata_i = 32'h0, rx_word = 32'h0, rdata, rx_data, tx_data, mrd, wd;
   logic reg_we_i = 1'b0, reg_re_i = 1'b0, slow = 1'b0, rx_send = 1'b0, tx_want = 1'b0, pend = 1'b0;
   logic rx_ready, rx_taken, rx_end, tx_ready, tx_load, tx_end, ack;
   pdm_pkg::pdm_mem_req_t mem;
   int errors = 0;
   int n_tests = 0;
   logic [31:0] rq[$], mq[$], tq[$];
   logic [11:0] offs[4] = '{pdm_pkg::OFF_RX_NXT_PTR, pdm_pkg::OFF_RX_NXT_CNT, pdm_pkg::OFF_TX_NXT_PTR,
      pdm_pkg::OFF_TX_NXT_CNT};
   logic [31:0] cmds[11] = '{32'h1, 32'h3, 32'h1, 32'h2, 32'h100, 32'h300, 32'h100, 32'h200, 32'h101, 32'h0,
      32'hfffffcfc};
   logic [31:0] sts[11] = '{32'h1, 32'h0, 32'h1, 32'h0, 32'h100, 32'h0, 32'h100, 32'h0, 32'h101, 32'h101, 32'h101};

   pdm_channel dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(rdata), .rx_ready_i(rx_ready), .rx_data_i(rx_data),
      .rx_taken_o(rx_taken), .rx_end_o(rx_end), .tx_ready_i(tx_ready), .tx_data_o(tx_data), .tx_load_o(tx_load),
      .tx_end_o(tx_end), .mem_o(mem), .mem_ack_i(ack), .mem_rdata_i(mrd));
   pdm_partner far_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .slow_i(slow), .rx_send_i(rx_send),
      .rx_word_i(rx_word), .tx_want_i(tx_want), .rx_ready_o(rx_ready), .rx_data_o(rx_data),
      .rx_taken_i(rx_taken), .tx_ready_o(tx_ready), .tx_load_i(tx_load), .mem_i(mem), .mem_ack_o(ack),
      .mem_rdata_o(mrd));

   initial begin
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   // ==========================================================
   // Tasks
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask

   // A gap cycle follows every access so a strobe is never raised in the step that lowers it.
   task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
      reg_we_i <= w;
      reg_re_i <= !w;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge clk_sys_i);
      reg_we_i <= 1'b0;
      reg_re_i <= 1'b0;
      @(posedge clk_sys_i);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      rq.push_back(e);
      acc(1'b0, a, 32'h0000_0000);
   endtask

   task automatic send(input logic [31:0] a);
      wd = $urandom();
      rx_word <= wd;
      rx_send <= 1'b1;
      @(posedge clk_sys_i);
      rx_send <= 1'b0;
      mq.push_back(a);
      mq.push_back(wd);
   endtask

   task automatic drain();
      for (int i = 0; i < 300 && (mq.size() + tq.size()) > 0; i++) @(posedge clk_sys_i);
      chk("pending results", 32'h0, 32'(mq.size() + tq.size()));
      repeat (3) @(posedge clk_sys_i);
   endtask

   task automatic end_of_test();
      $display("comparisons %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // ==========================================================
   // Result monitor
   always @(negedge clk_sys_i) begin
      if (pend) chk("read data", rq.size() > 0 ? rq.pop_front() : 32'hx, rdata);
      if (mem.req && ack && mem.we) begin
         chk("memory address", mq.size() > 0 ? mq.pop_front() : 32'hx, mem.addr);
         chk("memory data", mq.size() > 0 ? mq.pop_front() : 32'hx, mem.wdata);
      end
      if (tx_load) chk("transmit data", tq.size() > 0 ? tq.pop_front() : 32'hx, tx_data);
      pend = reg_re_i;
   end

   initial begin
      repeat (20000) @(posedge clk_sys_i);
      errors++;
      end_of_test();
   end

   // ==========================================================
   // Stimulus
   initial begin
      void'($urandom(32'h0d03b25f));
      repeat (5) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      rd(pdm_pkg::OFF_STATUS, 32'h0);
      rd(pdm_pkg::OFF_COMMAND, 32'h0);
      rd(12'h200, 32'h0);
      // Nonzero current counts keep the next values from being chained away while they are read back.
      acc(1'b1, pdm_pkg::OFF_RX_CUR_CNT, 32'h1);
      acc(1'b1, pdm_pkg::OFF_TX_CUR_CNT, 32'h1);
      for (int i = 0; i < 4; i++) begin
         wd = $urandom();
         acc(1'b1, offs[i], wd);
         rd(offs[i], i[0] ? {16'h0000, wd[15:0]} : wd);
      end
      for (int i = 0; i < 11; i++) begin
         acc(1'b1, pdm_pkg::OFF_COMMAND, cmds[i]);
         rd(pdm_pkg::OFF_STATUS, sts[i]);
      end
      acc(1'b1, pdm_pkg::OFF_RX_CUR_PTR, 32'h0000_1000);
      acc(1'b1, pdm_pkg::OFF_RX_CUR_CNT, 32'h2);
      acc(1'b1, pdm_pkg::OFF_RX_NXT_PTR, 32'h0000_2000);
      acc(1'b1, pdm_pkg::OFF_RX_NXT_CNT, 32'h1);
      acc(1'b1, pdm_pkg::OFF_COMMAND, 32'h2);
      send(32'h0000_1000);
      repeat (12) @(posedge clk_sys_i);
      chk("queued writes", 32'h2, 32'(mq.size()));
      acc(1'b1, pdm_pkg::OFF_COMMAND, 32'h1);
      drain();
      send(32'h0000_1001);
      drain();
      send(32'h0000_2000);
      drain();
      chk("receive end", 32'h1, 32'(rx_end));
      rd(pdm_pkg::OFF_RX_NXT_CNT, 32'h0);
      rd(pdm_pkg::OFF_RX_CUR_PTR, 32'h0000_2001);
      acc(1'b1, pdm_pkg::OFF_RX_NXT_CNT, 32'h0);
      chk("receive end", 32'h0, 32'(rx_end));
      slow <= 1'b1;
      acc(1'b1, pdm_pkg::OFF_TX_CUR_PTR, 32'h0000_3000);
      acc(1'b1, pdm_pkg::OFF_TX_CUR_CNT, 32'h1);
      acc(1'b1, pdm_pkg::OFF_TX_NXT_PTR, 32'h0000_4000);
      acc(1'b1, pdm_pkg::OFF_TX_NXT_CNT, 32'h1);
      tq.push_back(32'h0000_3000 ^ 32'h5a5a_5a5a);
      tq.push_back(32'h0000_4000 ^ 32'h5a5a_5a5a);
      tx_want <= 1'b1;
      drain();
      tx_want <= 1'b0;
      chk("transmit end", 32'h1, 32'(tx_end));
      rd(pdm_pkg::OFF_TX_CUR_PTR, 32'h0000_4001);
      acc(1'b1, pdm_pkg::OFF_TX_CUR_CNT, 32'h0);
      chk("transmit end", 32'h0, 32'(tx_end));
      repeat (3) @(posedge clk_sys_i);
      end_of_test();
   end
endmodule

`default_nettype wire
